// >>> design/gpab_pkg.sv
// package for the two-port general purpose i/o block
// assumes an 8-bit register port and a single 125 MHz core clock
package gpab_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] GPAB_OFS_PA_PINS = 8'h05;
	localparam logic [7:0] GPAB_OFS_PB_PINS = 8'h06;
	localparam logic [7:0] GPAB_OFS_ICR = 8'h0B;
	localparam logic [7:0] GPAB_OFS_OPTION = 8'h81;
	localparam logic [7:0] GPAB_OFS_PA_DIR = 8'h85;
	localparam logic [7:0] GPAB_OFS_PB_DIR = 8'h86;
	localparam logic [7:0] GPAB_OFS_PROG = 8'h8F;
	localparam logic [7:0] GPAB_OFS_ACFG = 8'h9F;
	// ****************************************
	// field positions
	// ****************************************
	localparam int GPAB_OPT_PU_N_BIT = 7;
	localparam int GPAB_OPT_EDGE_BIT = 6;
	localparam int GPAB_ICR_CHG_FLAG_BIT = 0;
	localparam int GPAB_ICR_EXT_FLAG_BIT = 1;
	localparam int GPAB_ICR_CHG_EN_BIT = 3;
	localparam int GPAB_ICR_EXT_EN_BIT = 4;
	localparam int GPAB_ACFG_FMT_BIT = 7;
	localparam int GPAB_PA_T0_BIT = 4;
	localparam int GPAB_PA_SS_BIT = 5;
	localparam int GPAB_PB_PROG_BIT = 3;
	localparam int GPAB_PB_EXT_BIT = 0;
	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int GPAB_PA_W = 6;
	localparam int GPAB_PB_W = 8;
	localparam logic [5:0] GPAB_RST_PA_DIR = 6'h3F;
	localparam logic [7:0] GPAB_RST_PB_DIR = 8'hFF;
	localparam logic [7:0] GPAB_RST_OPTION = 8'hFF;
	localparam logic [4:0] GPAB_RST_ACFG = 5'h00;
	localparam logic GPAB_RST_LV_PROG = 1'b1;
endpackage : gpab_pkg

// >>> design/gpab_sync.sv
// two-flop level synchroniser for a group of pins
// assumes inputs are levels; only the second stage is read outside
`timescale 1ns/1ns
module gpab_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule : gpab_sync

// >>> design/gpab_top.sv
// general purpose i/o ports a (6 bit) and b (8 bit)
// assumes a core register port with read data one cycle after the strobe
`timescale 1ns/1ns
module gpab_top
	import gpab_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [7:0] rdata,
	input wire logic [5:0] pa_in,
	output logic [5:0] pa_out,
	output logic [5:0] pa_oe,
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	output logic [7:0] pb_pullup,
	input wire logic ssp_ss_en,
	output logic ssp_ss,
	output logic timer0_clock_in,
	output logic lv_program_enable,
	output logic port_change_irq,
	output logic ext_int_irq,
	input wire logic sleep_mode,
	output logic wake
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [5:0] pa_lat;
		logic [5:0] pa_dir;
		logic [4:0] acfg;
		logic [7:0] pb_lat;
		logic [7:0] pb_dir;
		logic [7:0] opt;
		logic chg_flag;
		logic ext_flag;
		logic chg_en;
		logic ext_en;
		logic lv_prog;
		logic [3:0] pb_old;
		logic pb0_prev;
		logic [7:0] rdata;
		logic [5:0] pa_out;
		logic [5:0] pa_oe;
		logic [7:0] pb_out;
		logic [7:0] pb_oe;
		logic [7:0] pb_pu;
		logic ss;
		logic t0;
		logic prog_pin;
		logic chg_irq;
		logic ext_irq;
		logic wake;
	} gpab_state_t;

	gpab_state_t st_r;
	gpab_state_t st_nxt;
	logic [5:0] pa_s;
	logic [7:0] pb_s;
	logic [3:0] mismatch;
	logic ext_edge;
	logic [5:0] pa_ana;

	// ****************************************
	// analog pin decode
	// ****************************************
	// mask of analog pins on port a, bit 4 never analog
	function automatic logic [5:0] gpab_analog_mask(input logic [3:0] cfg);
		logic [5:0] m;
		m = 6'h2F;
		if (cfg[3:1] == 3'b011) begin
			m = 6'h00;
		end else if (cfg == 4'h4 || cfg == 4'h5 || cfg == 4'hD || cfg == 4'hE || cfg == 4'hF) begin
			m = 6'h0F;
		end
		return m;
	endfunction : gpab_analog_mask

	// ****************************************
	// pin synchronisers
	// ****************************************
	gpab_sync #(.W(GPAB_PA_W)) u_sync_pa (
		.clk(clk),
		.nrst(nrst),
		.d(pa_in),
		.q(pa_s)
	);

	gpab_sync #(.W(GPAB_PB_W)) u_sync_pb (
		.clk(clk),
		.nrst(nrst),
		.d(pb_in),
		.q(pb_s)
	);

	assign pa_ana = gpab_analog_mask(st_r.acfg[3:0]);
	assign mismatch = (pb_s[7:4] ^ st_r.pb_old) & st_r.pb_dir[7:4];
	assign ext_edge = st_r.opt[GPAB_OPT_EDGE_BIT] ?
		(pb_s[GPAB_PB_EXT_BIT] & ~st_r.pb0_prev) :
		(~pb_s[GPAB_PB_EXT_BIT] & st_r.pb0_prev);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic pb_acc;
		logic [7:0] pb_rd;
		pb_acc = 1'b0;
		pb_rd = pb_s;
		st_nxt = st_r;
		if (st_r.lv_prog) begin
			pb_rd[GPAB_PB_PROG_BIT] = 1'b0;
		end
		// register writes
		if (we) begin
			unique case (addr)
				GPAB_OFS_PA_PINS: st_nxt.pa_lat = wdata[5:0];
				GPAB_OFS_PA_DIR: st_nxt.pa_dir = wdata[5:0];
				GPAB_OFS_ACFG: st_nxt.acfg = {wdata[GPAB_ACFG_FMT_BIT], wdata[3:0]};
				GPAB_OFS_PB_PINS: begin
					st_nxt.pb_lat = wdata;
					pb_acc = 1'b1;
				end
				GPAB_OFS_PB_DIR: st_nxt.pb_dir = wdata;
				GPAB_OFS_OPTION: st_nxt.opt = wdata;
				GPAB_OFS_PROG: st_nxt.lv_prog = wdata[0];
				GPAB_OFS_ICR: begin
					st_nxt.chg_flag = wdata[GPAB_ICR_CHG_FLAG_BIT];
					st_nxt.ext_flag = wdata[GPAB_ICR_EXT_FLAG_BIT];
					st_nxt.chg_en = wdata[GPAB_ICR_CHG_EN_BIT];
					st_nxt.ext_en = wdata[GPAB_ICR_EXT_EN_BIT];
				end
				default: ;
			endcase
		end
		// register reads, data one cycle later
		st_nxt.rdata = 8'h00;
		if (re) begin
			unique case (addr)
				GPAB_OFS_PA_PINS: st_nxt.rdata = {2'b00, pa_s & ~pa_ana};
				GPAB_OFS_PA_DIR: st_nxt.rdata = {2'b00, st_r.pa_dir};
				GPAB_OFS_ACFG: st_nxt.rdata = {st_r.acfg[4], 3'b000, st_r.acfg[3:0]};
				GPAB_OFS_PB_PINS: begin
					st_nxt.rdata = pb_rd;
					pb_acc = 1'b1;
				end
				GPAB_OFS_PB_DIR: st_nxt.rdata = st_r.pb_dir;
				GPAB_OFS_OPTION: st_nxt.rdata = st_r.opt;
				GPAB_OFS_PROG: st_nxt.rdata = {7'h00, st_r.lv_prog};
				GPAB_OFS_ICR: st_nxt.rdata = {3'b000, st_r.ext_en, st_r.chg_en, 1'b0,
					st_r.ext_flag, st_r.chg_flag};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		// change detection, access relatches the old value
		if (pb_acc) begin
			st_nxt.pb_old = pb_s[7:4];
		end
		if (|mismatch) begin
			st_nxt.chg_flag = 1'b1;
		end
		// external edge, set beats clear
		st_nxt.pb0_prev = pb_s[GPAB_PB_EXT_BIT];
		if (ext_edge) begin
			st_nxt.ext_flag = 1'b1;
		end
		// pin drivers
		st_nxt.pa_out = st_r.pa_lat;
		st_nxt.pa_oe = ~st_r.pa_dir;
		st_nxt.pa_out[GPAB_PA_T0_BIT] = 1'b0;
		st_nxt.pa_oe[GPAB_PA_T0_BIT] = ~st_r.pa_dir[GPAB_PA_T0_BIT] &
			~st_r.pa_lat[GPAB_PA_T0_BIT];
		if (ssp_ss_en) begin
			st_nxt.pa_oe[GPAB_PA_SS_BIT] = 1'b0;
		end
		st_nxt.pb_out = st_r.pb_lat;
		st_nxt.pb_oe = ~st_r.pb_dir;
		if (st_r.lv_prog) begin
			st_nxt.pb_oe[GPAB_PB_PROG_BIT] = 1'b0;
		end
		st_nxt.pb_pu = st_r.opt[GPAB_OPT_PU_N_BIT] ? 8'h00 : st_r.pb_dir;
		// peripheral side signals
		st_nxt.ss = pa_s[GPAB_PA_SS_BIT] | ~ssp_ss_en;
		st_nxt.t0 = pa_s[GPAB_PA_T0_BIT];
		st_nxt.prog_pin = st_r.lv_prog & pb_s[GPAB_PB_PROG_BIT];
		st_nxt.chg_irq = st_r.chg_flag & st_r.chg_en;
		st_nxt.ext_irq = st_r.ext_flag & st_r.ext_en;
		st_nxt.wake = st_r.chg_flag & st_r.chg_en & sleep_mode;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.pa_dir <= GPAB_RST_PA_DIR;
			st_r.acfg <= GPAB_RST_ACFG;
			st_r.pb_dir <= GPAB_RST_PB_DIR;
			st_r.opt <= GPAB_RST_OPTION;
			st_r.lv_prog <= GPAB_RST_LV_PROG;
			st_r.ss <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;
	assign pa_out = st_r.pa_out;
	assign pa_oe = st_r.pa_oe;
	assign pb_out = st_r.pb_out;
	assign pb_oe = st_r.pb_oe;
	assign pb_pullup = st_r.pb_pu;
	assign ssp_ss = st_r.ss;
	assign timer0_clock_in = st_r.t0;
	assign lv_program_enable = st_r.prog_pin;
	assign port_change_irq = st_r.chg_irq;
	assign ext_int_irq = st_r.ext_irq;
	assign wake = st_r.wake;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_pa_upper_zero: assert property (
		(re && (addr == GPAB_OFS_PA_PINS || addr == GPAB_OFS_PA_DIR)) |=> rdata[7:6] == 2'b00)
		else $error("port a upper bits not zero");
	a_analog_read_zero: assert property (
		(re && addr == GPAB_OFS_PA_PINS && st_r.acfg[3:0] == 4'h0) |=> rdata[3:0] == 4'h0)
		else $error("analog pin read not zero");
	a_bit4_open_drain: assert property (
		pa_oe[GPAB_PA_T0_BIT] |-> !pa_out[GPAB_PA_T0_BIT])
		else $error("bit 4 drives high");
	a_pullup_output_off: assert property (
		(pb_pullup & pb_oe) == 8'h00)
		else $error("pull-up on with driver");
	a_pullup_global: assert property (
		st_r.opt[GPAB_OPT_PU_N_BIT] |=> pb_pullup == 8'h00)
		else $error("pull-up on while disabled");
	a_input_floats: assert property (
		st_r.pb_dir[1] |=> !pb_oe[1])
		else $error("input pin driven");
	a_change_sets: assert property (
		(|mismatch) |=> st_r.chg_flag)
		else $error("mismatch did not set flag");
	a_change_beats_clear: assert property (
		((|mismatch) && we && addr == GPAB_OFS_ICR && !wdata[0]) |=> st_r.chg_flag)
		else $error("clear beat mismatch");
	a_ext_edge_flag: assert property (
		(st_r.opt[GPAB_OPT_EDGE_BIT] && pb_s[0] && !st_r.pb0_prev) |=> st_r.ext_flag)
		else $error("edge did not set flag");
	a_prog_pin_undriven: assert property (
		st_r.lv_prog |=> !pb_oe[GPAB_PB_PROG_BIT])
		else $error("bit 3 driven in programming mode");
	a_pb_write_latch: assert property (
		(we && addr == GPAB_OFS_PB_PINS) |=> ##1 pb_out == $past(wdata, 2))
		else $error("port b latch not written");
	a_wake_sleep: assert property (
		(st_r.chg_flag && st_r.chg_en && sleep_mode) |=> wake)
		else $error("no wake on change");

	// ****************************************
	// pin, flag and read data assertions
	// ****************************************
	a_bit4_latch_floats: assert property (
		st_r.pa_lat[GPAB_PA_T0_BIT] |=> !pa_oe[GPAB_PA_T0_BIT])
		else $error("bit 4 drives a latched one");
	a_ext_fall_flag: assert property (
		(!st_r.opt[GPAB_OPT_EDGE_BIT] && !pb_s[0] && st_r.pb0_prev) |=> st_r.ext_flag)
		else $error("falling edge did not set flag");
	a_ext_no_edge: assert property (
		(pb_s[0] == st_r.pb0_prev && !st_r.ext_flag && !(we && addr == GPAB_OFS_ICR))
			|=> !st_r.ext_flag)
		else $error("ext flag set without edge");
	a_output_excluded: assert property (
		(st_r.pb_dir[7:4] == 4'h7 && pb_s[6:4] == st_r.pb_old[2:0] && !st_r.chg_flag &&
			!(we && addr == GPAB_OFS_ICR)) |=> !st_r.chg_flag)
		else $error("output pin set change flag");
	a_read_relatches: assert property (
		(re && addr == GPAB_OFS_PB_PINS) |=> st_r.pb_old == $past(pb_s[7:4]))
		else $error("read did not relatch");
	a_clear_no_mismatch: assert property (
		(we && addr == GPAB_OFS_ICR && !wdata[GPAB_ICR_CHG_FLAG_BIT] &&
			pb_s[7:4] == st_r.pb_old) |=> !st_r.chg_flag)
		else $error("clear without mismatch ignored");
	a_pa_drives_latch: assert property (
		!st_r.pa_dir[0] |=> pa_oe[0] && pa_out[0] == $past(st_r.pa_lat[0]))
		else $error("port a output not driven");
	a_pb_drives_latch: assert property (
		!st_r.pb_dir[7] |=> pb_oe[7] && pb_out[7] == $past(st_r.pb_lat[7]))
		else $error("port b output not driven");
	a_ss_takes_pin: assert property (
		ssp_ss_en |=> !pa_oe[GPAB_PA_SS_BIT])
		else $error("select pin still driven");
	a_rdata_idle_zero: assert property (
		!re |=> rdata == 8'h00)
		else $error("read data outside read cycle");
	a_prog_reads_zero: assert property (
		(re && addr == GPAB_OFS_PB_PINS && st_r.lv_prog) |=> !rdata[GPAB_PB_PROG_BIT])
		else $error("programming pin read not zero");
	a_change_irq_follows: assert property (
		(st_r.chg_flag && st_r.chg_en) |=> port_change_irq)
		else $error("change irq missing");
	a_pullup_input_on: assert property (
		(!st_r.opt[GPAB_OPT_PU_N_BIT] && st_r.pb_dir[2]) |=> pb_pullup[2])
		else $error("pull-up off on input");
	a_wake_needs_sleep: assert property (
		!sleep_mode |=> !wake)
		else $error("wake while awake");
	a_timer_pin_follows: assert property (
		pa_s[GPAB_PA_T0_BIT] |=> timer0_clock_in)
		else $error("timer clock not following pin");
endmodule : gpab_top

// >>> dv/gpab_board.sv
// board model: pins of both ports, keys drive the inputs
// assumes oe high while the block drives a pin
`timescale 1ns/1ns
module gpab_board (
	input wire logic [5:0] pa_out,
	input wire logic [5:0] pa_oe,
	input wire logic [7:0] pb_out,
	input wire logic [7:0] pb_oe,
	input wire logic [5:0] key_a,
	input wire logic [7:0] key_b,
	output logic [5:0] pa_in,
	output logic [7:0] pb_in
);
	// ****************************************
	// pin levels
	// ****************************************
	// driven pin shows the block, else the key
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & key_a);
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & key_b);
endmodule : gpab_board

// >>> dv/tb_top.sv
// self-checking bench for the two-port i/o block
// assumes the board model resolves pins from block drives and keys
`timescale 1ns/1ns
module tb_top
	import gpab_pkg::*;
;
	logic clk, nrst, we, re, ssp_ss_en, sleep_mode, ssp_ss, t0_clk, prog_en, chg_irq;
	logic ext_irq, wake;
	logic [7:0] addr, wdata, rdata, pb_in, pb_out, pb_oe, pb_pullup, key_b;
	logic [5:0] pa_in, pa_out, pa_oe, key_a;
	int errors = 0;
	int cmp_count = 0;
	logic [7:0] codes [5] = '{8'h00, 8'h04, 8'h0D, 8'h07, 8'h06};
	logic [7:0] reads [5] = '{8'h10, 8'h30, 8'h30, 8'h3F, 8'h3F};
	gpab_top gpab_top_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .we(we),
		.re(re), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in),
		.pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup), .ssp_ss_en(ssp_ss_en),
		.ssp_ss(ssp_ss), .timer0_clock_in(t0_clk), .lv_program_enable(prog_en),
		.port_change_irq(chg_irq), .ext_int_irq(ext_irq), .sleep_mode(sleep_mode), .wake(wake));
	gpab_board gpab_board_inst (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
		.pb_oe(pb_oe), .key_a(key_a), .key_b(key_b), .pa_in(pa_in), .pb_in(pb_in));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		chk("rdata", rdata, e);
	endtask : rd
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		cyc(3);
		rd(GPAB_OFS_PA_PINS, 8'h00);
		rd(GPAB_OFS_PA_DIR, 8'h3F);
		rd(GPAB_OFS_PB_DIR, 8'hFF);
		rd(GPAB_OFS_ACFG, 8'h00);
		rd(8'h40, 8'h00);
		chk("pb_pullup", pb_pullup, 8'h00);
		chk("pa_oe", {2'h0, pa_oe}, 8'h00);
	endtask : t_reset
	task automatic t_analog();
		@(posedge clk);
		key_a <= 6'h3F;
		for (int i = 0; i < 5; i++) begin
			wr(GPAB_OFS_ACFG, codes[i]);
			rd(GPAB_OFS_ACFG, codes[i]);
			rd(GPAB_OFS_PA_PINS, reads[i]);
		end
	endtask : t_analog
	task automatic t_port_a();
		@(posedge clk);
		key_a <= 6'h3A;
		wr(GPAB_OFS_PA_PINS, 8'h15);
		wr(GPAB_OFS_PA_DIR, 8'h00);
		cyc(3);
		chk("pa_oe", {2'h0, pa_oe}, 8'h2F);
		chk("pa_out", {2'h0, pa_out}, 8'h05);
		chk("t0", {7'h0, t0_clk}, 8'h01);
		rd(GPAB_OFS_PA_PINS, 8'h15);
		wr(GPAB_OFS_PA_DIR, 8'hFF);
		rd(GPAB_OFS_PA_DIR, 8'h3F);
		cyc(3);
		rd(GPAB_OFS_PA_PINS, 8'h3A);
	endtask : t_port_a
	task automatic t_shared();
		wr(GPAB_OFS_ACFG, 8'h06);
		ssp_ss_en <= 1'b1;
		key_a <= 6'h1A;
		wr(GPAB_OFS_PA_DIR, 8'h00);
		cyc(3);
		chk("pa_oe", {2'h0, pa_oe}, 8'h0F);
		chk("ssp_ss", {7'h0, ssp_ss}, 8'h00);
		@(posedge clk);
		ssp_ss_en <= 1'b0;
		wr(GPAB_OFS_PA_DIR, 8'hFF);
	endtask : t_shared
	task automatic t_change();
		wr(GPAB_OFS_ICR, 8'h08);
		wr(GPAB_OFS_PB_DIR, 8'h7F);
		wr(GPAB_OFS_PB_PINS, 8'h80);
		cyc(6);
		chk("pb_oe", pb_oe, 8'h80);
		chk("pb_out", pb_out, 8'h80);
		rd(GPAB_OFS_ICR, 8'h08);
		@(posedge clk);
		key_b <= 8'h10;
		cyc(5);
		chk("chg_irq", {7'h0, chg_irq}, 8'h01);
		rd(GPAB_OFS_ICR, 8'h09);
		@(posedge clk);
		sleep_mode <= 1'b1;
		cyc(3);
		chk("wake", {7'h0, wake}, 8'h01);
		@(posedge clk);
		sleep_mode <= 1'b0;
		wr(GPAB_OFS_ICR, 8'h08);
		cyc(2);
		rd(GPAB_OFS_ICR, 8'h09);
		rd(GPAB_OFS_PB_PINS, 8'h90);
		wr(GPAB_OFS_ICR, 8'h08);
		cyc(2);
		rd(GPAB_OFS_ICR, 8'h08);
	endtask : t_change
	task automatic t_ext();
		wr(GPAB_OFS_ICR, 8'h10);
		key_b <= 8'h11;
		cyc(5);
		chk("ext_irq", {7'h0, ext_irq}, 8'h01);
		wr(GPAB_OFS_ICR, 8'h10);
		key_b <= 8'h10;
		cyc(5);
		rd(GPAB_OFS_ICR, 8'h10);
		wr(GPAB_OFS_OPTION, 8'hBF);
		key_b <= 8'h11;
		cyc(5);
		rd(GPAB_OFS_ICR, 8'h10);
		@(posedge clk);
		key_b <= 8'h10;
		cyc(5);
		rd(GPAB_OFS_ICR, 8'h12);
	endtask : t_ext
	task automatic t_prog_pullup();
		@(posedge clk);
		key_b <= 8'h18;
		cyc(3);
		rd(GPAB_OFS_PB_PINS, 8'h90);
		chk("prog_en", {7'h0, prog_en}, 8'h01);
		wr(GPAB_OFS_PROG, 8'h00);
		cyc(3);
		rd(GPAB_OFS_PB_PINS, 8'h98);
		chk("prog_en", {7'h0, prog_en}, 8'h00);
		wr(GPAB_OFS_OPTION, 8'h7F);
		cyc(2);
		chk("pb_pullup", pb_pullup, 8'h7F);
		wr(GPAB_OFS_OPTION, 8'hFF);
		cyc(2);
		chk("pb_pullup", pb_pullup, 8'h00);
	endtask : t_prog_pullup
	task automatic tally_and_finish();
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		nrst = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		we = 1'b0;
		re = 1'b0;
		ssp_ss_en = 1'b0;
		sleep_mode = 1'b0;
		key_a = 6'h2F;
		key_b = 8'h00;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_analog();
		t_port_a();
		t_shared();
		t_change();
		t_ext();
		t_prog_pullup();
		tally_and_finish();
	end
endmodule : tb_top
